// File: afp_regs.svh
// Purpose: Register offsets, field positions, reset values and timing counts for the angle filter block
// Assumes: 32-bit word registers on a plain strobe port, byte addresses
// Notes: Included by the design files
`ifndef AFP_REGS_SVH
`define AFP_REGS_SVH

`define AFP_OFF_CONFIG 8'h00
`define AFP_OFF_STATUS 8'h04
`define AFP_OFF_IRQ_STAT 8'h08
`define AFP_OFF_IRQ_EN 8'h0c
`define AFP_OFF_IRQ_CLR 8'h10
`define AFP_OFF_ANGLE 8'h14

// Config field positions
`define AFP_CFG_SF_LO 0
`define AFP_CFG_SF_HI 1
`define AFP_CFG_FTH_LO 2
`define AFP_CFG_FTH_HI 4
`define AFP_CFG_HYSTERESIS_SEL_LO 5
`define AFP_CFG_HYSTERESIS_SEL_HI 6
`define AFP_CFG_PM_LO 7
`define AFP_CFG_PM_HI 8
`define AFP_CFG_AUTO_LOWPOWER_EN 9
`define AFP_CFG_PWM 10
`define AFP_CFG_RESET 11'h000

// Status bits
`define AFP_ST_MAGNET 0
`define AFP_ST_FAST 1
`define AFP_ST_DEEP 2

// Interrupt bits: magnet lost, magnet found, deep entry
`define AFP_IRQ_LOST 0
`define AFP_IRQ_FOUND 1
`define AFP_IRQ_DEEP 2

`define AFP_IDLE_BAND 12'h004
`define AFP_IDLE_TIME_S 60
`define AFP_CLK_HZ 25000000
`define AFP_IDLE_CYCLES (`AFP_IDLE_TIME_S * `AFP_CLK_HZ)

`endif

// File: afp_pkg.sv
// Purpose: Types for the angle filter block
// Assumes: afp_regs.svh supplies the numbers
// Notes: Power state enumeration
package afp_pkg;
  typedef enum logic [1:0] {
    AFP_PWR_NORMAL,
    AFP_PWR_SELECTED,
    AFP_PWR_DEEPEST
  } afp_pwr_t;
endpackage : afp_pkg

// File: afp_filter.sv
// Purpose: Adaptive slow/fast angle filter
// Assumes: One new sample per sample strobe
// Notes: Slow path is a first-order IIR whose shift follows the step selection
`timescale 1ns/1ps
`default_nettype none
`include "afp_regs.svh"
module afp_filter
  import afp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Settings
  input wire logic [1:0] slow_filter_sel,
  input wire logic [2:0] fast_threshold_sel,
  // Samples
  input wire logic sample_valid,
  input wire logic [11:0] sample_angle,
  // Result
  output logic [11:0] filt_angle,
  output logic fast_active
);
  logic [15:0] acc;
  logic [11:0] diff;
  logic [4:0] up_th;
  logic [2:0] down_th;
  logic [3:0] shift;
  logic [15:0] target;
  logic [15:0] next_acc;
  logic next_fast;

  function automatic logic [11:0] afp_absdiff(input logic [11:0] a, input logic [11:0] b);
    afp_absdiff = (a > b) ? (a - b) : (b - a);
  endfunction : afp_absdiff

  assign diff = afp_absdiff(sample_angle, acc[15:4]);
  // Slow-to-fast and fast-to-slow thresholds
  assign up_th = (fast_threshold_sel == 3'h1) ? 5'h06 : (fast_threshold_sel == 3'h2) ? 5'h07 :
                 (fast_threshold_sel == 3'h3) ? 5'h09 : (fast_threshold_sel == 3'h4) ? 5'h12 :
                 (fast_threshold_sel == 3'h5) ? 5'h15 : (fast_threshold_sel == 3'h6) ? 5'h18 :
                 5'h0a;
  assign down_th = (fast_threshold_sel == 3'h7) ? 3'h4 : (fast_threshold_sel[2] ? 3'h2 : 3'h1);
  // Longer step delay uses a larger shift
  assign shift = 4'h4 - {2'h0, slow_filter_sel};
  assign target = {sample_angle, 4'h0};
  // Fast path enters above the up threshold and leaves at or below the down threshold
  assign next_fast = (fast_threshold_sel == 3'h0) ? 1'b0 :
                     (fast_active ? ({9'h000, diff} > {13'h0000, down_th}) : ({7'h00, diff} > {2'h0, up_th}));
  // Fast path jumps straight to the sample, settling within two samples
  assign next_acc = next_fast ? target :
                    ((target >= acc) ? (acc + ((target - acc) >> shift)) : (acc - ((acc - target) >> shift)));

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      acc <= 16'h0000;
      fast_active <= 1'b0;
      filt_angle <= 12'h000;
    end
    else if (sample_valid)
    begin
      acc <= next_acc;
      fast_active <= next_fast;
      filt_angle <= next_acc[15:4];
    end
  end
endmodule : afp_filter
`default_nettype wire

// File: afp_top.sv
// Purpose: Angle post-processing, magnet detection and low-power control
// Assumes: Front end delivers samples and a field-fail level on clk_sys
// Notes: Registers on a plain strobe port, read data one cycle later
// Behaviour
// - Fast filter acts only while angle change exceeds the selected threshold.
// - Three-bit threshold field; code zero means slow filter only.
// - Codes 1..7 use thresholds 6,7,9,18,21,24,10 up and 1,1,1,2,2,2,4 down.
// - With fast filter, output settles within two sampling periods after a step.
// - Output hysteresis of 0 to 3 LSB chosen by a configuration field.
// - Magnet-present flag clears when field strength is below minimum.
// - In PWM mode with magnet absent, output pin is held low.
// - State machine manages three low-power modes chosen by a mode field.
// - Angle within 4 LSB for one minute with auto enabled enters deepest mode.
// - One configuration bit enables the automatic idle timer.
// - Two-bit slow filter field sets step response from slowest to fastest.
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "afp_regs.svh"
module afp_top
  import afp_pkg::*;
#(
  parameter int unsigned IDLE_CYCLES = `AFP_IDLE_CYCLES
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Front end
  input wire logic sample_valid,
  input wire logic [11:0] sample_angle,
  input wire logic field_fail_level,
  // PWM frame level and outputs
  input wire logic pwm_frame_level,
  output logic out_pin,
  output logic [11:0] angle_out,
  output logic magnet_present,
  output logic [1:0] power_mode,
  output logic irq
);
  logic [10:0] config_reg;
  logic [2:0] irq_stat;
  logic [2:0] irq_en;
  logic field_sync1;
  logic field_sync2;
  logic [11:0] filt_angle;
  logic fast_active;
  logic [11:0] idle_ref;
  logic [31:0] idle_cnt;
  afp_pwr_t pwr_state;
  afp_pwr_t next_pwr;

  logic [1:0] slow_filter_sel;
  logic [2:0] fast_threshold_sel;
  logic [1:0] hysteresis_sel;
  logic [1:0] power_mode_sel;
  logic auto_lowpower_en;
  logic pwm_enable;
  logic wr_config;
  logic wr_irq_en;
  logic wr_irq_clr;
  logic [11:0] hysteresis_sel_diff;
  logic hysteresis_sel_move;
  logic [11:0] idle_diff;
  logic idle_moved;
  logic idle_done;
  logic magnet_now;
  logic [2:0] irq_events;
  logic [2:0] next_irq_stat;
  logic [31:0] read_mux;
  logic [1:0] pwr_code;

  function automatic logic [11:0] afp_dist(input logic [11:0] a, input logic [11:0] b);
    afp_dist = (a > b) ? (a - b) : (b - a);
  endfunction : afp_dist

  // Config fields
  assign slow_filter_sel = config_reg[`AFP_CFG_SF_HI:`AFP_CFG_SF_LO];
  assign fast_threshold_sel = config_reg[`AFP_CFG_FTH_HI:`AFP_CFG_FTH_LO];
  assign hysteresis_sel = config_reg[`AFP_CFG_HYSTERESIS_SEL_HI:`AFP_CFG_HYSTERESIS_SEL_LO];
  assign power_mode_sel = config_reg[`AFP_CFG_PM_HI:`AFP_CFG_PM_LO];
  assign auto_lowpower_en = config_reg[`AFP_CFG_AUTO_LOWPOWER_EN];
  assign pwm_enable = config_reg[`AFP_CFG_PWM];

  // Register decode
  assign wr_config = reg_wr && (reg_addr == `AFP_OFF_CONFIG);
  assign wr_irq_en = reg_wr && (reg_addr == `AFP_OFF_IRQ_EN);
  assign wr_irq_clr = reg_wr && (reg_addr == `AFP_OFF_IRQ_CLR);

  afp_filter u_filter (
    .clk_sys(clk_sys),
    .rst(rst),
    .slow_filter_sel(slow_filter_sel),
    .fast_threshold_sel(fast_threshold_sel),
    .sample_valid(sample_valid),
    .sample_angle(sample_angle),
    .filt_angle(filt_angle),
    .fast_active(fast_active)
  );

  // Output only moves when the change exceeds the hysteresis band
  assign hysteresis_sel_diff = afp_dist(filt_angle, angle_out);
  assign hysteresis_sel_move = hysteresis_sel_diff > {10'h000, hysteresis_sel};

  // Idle detection against a reference angle
  assign idle_diff = afp_dist(filt_angle, idle_ref);
  assign idle_moved = idle_diff > `AFP_IDLE_BAND;
  assign idle_done = idle_cnt >= (IDLE_CYCLES - 32'h1);
  assign magnet_now = ~field_sync2;

  // Power state machine
  always_comb
  begin
    next_pwr = pwr_state;
    unique case (pwr_state)
      AFP_PWR_NORMAL:
        if (power_mode_sel != 2'h0)
          next_pwr = AFP_PWR_SELECTED;
      AFP_PWR_SELECTED:
        if (power_mode_sel == 2'h0)
          next_pwr = AFP_PWR_NORMAL;
      AFP_PWR_DEEPEST:
        if (!auto_lowpower_en || idle_moved)
          next_pwr = (power_mode_sel == 2'h0) ? AFP_PWR_NORMAL : AFP_PWR_SELECTED;
    endcase
    if (auto_lowpower_en && idle_done && !idle_moved)
      next_pwr = AFP_PWR_DEEPEST;
  end

  assign pwr_code = (pwr_state == AFP_PWR_DEEPEST) ? 2'h3 :
                    (pwr_state == AFP_PWR_SELECTED) ? power_mode_sel : 2'h0;

  // Interrupt events; set wins over clear
  assign irq_events[`AFP_IRQ_LOST] = magnet_present && !magnet_now;
  assign irq_events[`AFP_IRQ_FOUND] = !magnet_present && magnet_now;
  assign irq_events[`AFP_IRQ_DEEP] = (next_pwr == AFP_PWR_DEEPEST) && (pwr_state != AFP_PWR_DEEPEST);
  assign next_irq_stat = (irq_stat & ~(wr_irq_clr ? reg_wdata[2:0] : 3'h0)) | irq_events;

  assign read_mux = (reg_addr == `AFP_OFF_CONFIG) ? {21'h000000, config_reg} :
                    (reg_addr == `AFP_OFF_STATUS) ? {27'h0000000, pwr_code,
                      pwr_state == AFP_PWR_DEEPEST, fast_active, magnet_present} :
                    (reg_addr == `AFP_OFF_IRQ_STAT) ? {29'h00000000, irq_stat} :
                    (reg_addr == `AFP_OFF_IRQ_EN) ? {29'h00000000, irq_en} :
                    (reg_addr == `AFP_OFF_ANGLE) ? {20'h00000, angle_out} : 32'h00000000;

  // Field-fail level comes from the analog side
  always_ff @(posedge clk_sys)
  begin
    field_sync1 <= field_fail_level;
    field_sync2 <= field_sync1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      config_reg <= `AFP_CFG_RESET;
      irq_en <= 3'h0;
      irq_stat <= 3'h0;
      reg_rdata <= 32'h00000000;
    end
    else
    begin
      if (wr_config)
        config_reg <= reg_wdata[10:0];
      if (wr_irq_en)
        irq_en <= reg_wdata[2:0];
      irq_stat <= next_irq_stat;
      reg_rdata <= reg_rd ? read_mux : 32'h00000000;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      magnet_present <= 1'b0;
      angle_out <= 12'h000;
      out_pin <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      magnet_present <= magnet_now;
      if (hysteresis_sel_move)
        angle_out <= filt_angle;
      out_pin <= pwm_enable && magnet_now && pwm_frame_level;
      irq <= |(next_irq_stat & irq_en);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pwr_state <= AFP_PWR_NORMAL;
      power_mode <= 2'h0;
      idle_ref <= 12'h000;
      idle_cnt <= 32'h00000000;
    end
    else
    begin
      pwr_state <= next_pwr;
      power_mode <= (next_pwr == AFP_PWR_DEEPEST) ? 2'h3 :
                    (next_pwr == AFP_PWR_SELECTED) ? power_mode_sel : 2'h0;
      if (!auto_lowpower_en || idle_moved)
      begin
        idle_ref <= filt_angle;
        idle_cnt <= 32'h00000000;
      end
      else if (!idle_done)
        idle_cnt <= idle_cnt + 32'h1;
    end
  end
endmodule : afp_top
`default_nettype wire

// File: afp_asserts.sv
// Purpose: Port checks for afp_top
// Assumes: Config is tracked by snooping register writes
// Notes: Bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module afp_asserts
#(
  parameter int unsigned IDLE_CYCLES = 50
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register writes
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  // Front end
  input wire logic sample_valid,
  input wire logic field_fail_level,
  input wire logic pwm_frame_level,
  // Outputs
  input wire logic out_pin,
  input wire logic [11:0] angle_out,
  input wire logic magnet_present,
  input wire logic [1:0] power_mode
);
  logic [10:0] cfg;
  logic [31:0] still;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      cfg <= 11'h000;
    else if (reg_wr && reg_addr == 8'h00)
      cfg <= reg_wdata[10:0];
  end
  // Cycles since auto low power was switched on
  always_ff @(posedge clk_sys)
  begin
    if (rst || !cfg[9])
      still <= 32'h0;
    else
      still <= still + 32'h1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_field_hi;
    field_fail_level [*4];
  endsequence
  sequence s_field_lo;
    !field_fail_level [*5];
  endsequence
  a_mag_lost: assert property (s_field_hi |-> !magnet_present)
    else $error("magnet flag kept");
  a_mag_back: assert property (s_field_lo |-> magnet_present)
    else $error("magnet flag not restored");
  a_pin_low: assert property (!magnet_present [*2] |-> !out_pin)
    else $error("pin high without magnet");
  a_pin_frame: assert property (out_pin |-> $past(pwm_frame_level))
    else $error("pin high outside frame");
  a_angle_cause: assert property ($changed(angle_out) |-> $past(sample_valid, 2) || $past(sample_valid, 3))
    else $error("angle moved without sample");
  a_mode_follow: assert property ($stable(cfg) && power_mode != 2'h3 |-> power_mode == cfg[8:7])
    else $error("mode differs from setting");
  a_deep_auto: assert property ((!cfg[9] && cfg[8:7] != 2'h3) [*3] |-> power_mode != 2'h3)
    else $error("deep mode without auto");
  a_deep_wait: assert property ($rose(power_mode == 2'h3) && cfg[8:7] != 2'h3 |-> still >= IDLE_CYCLES - 2)
    else $error("deep mode too early");
endmodule : afp_asserts
`default_nettype wire

// File: afp_frontend.sv
// Purpose: Front end stand-in feeding samples and frame levels
// Assumes: One sample every PERIOD cycles
// Notes: Angle lines carry the inverse between samples
`timescale 1ns/1ps
`default_nettype none
module afp_frontend
#(
  parameter int unsigned PERIOD = 8
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Requested angle
  input wire logic [11:0] target,
  // Towards the block
  output logic sample_valid,
  output logic [11:0] sample_angle,
  output logic pwm_frame_level
);
  logic [7:0] cnt;
  logic [7:0] pat;
  assign sample_valid = !rst && cnt == 8'h0;
  assign sample_angle = sample_valid ? target : ~target;
  assign pwm_frame_level = !rst && pat[7];
  always_ff @(posedge clk_sys)
  begin
    if (rst || cnt == 8'(PERIOD - 1))
      cnt <= 8'h0;
    else
      cnt <= cnt + 8'h1;
  end
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      pat <= 8'h5a;
    else
      pat <= {pat[6:0], pat[7] ^ pat[5] ^ pat[4] ^ pat[3]};
  end
endmodule : afp_frontend
`default_nettype wire

// File: tb.sv
// Purpose: Self-checking bench for afp_top
// Assumes: Idle time shortened to 50 cycles
// Notes: Outputs read just after an edge show pre-edge values
`timescale 1ns/1ps
`default_nettype none
bind afp_top afp_asserts #(.IDLE_CYCLES(IDLE_CYCLES)) u_chk (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr,
  .sample_valid, .field_fail_level, .pwm_frame_level, .out_pin, .angle_out, .magnet_present, .power_mode);
module tb;
  logic clk_sys, rst, reg_wr, reg_rd, field_fail_level, sample_valid, pwm_frame_level, out_pin, magnet_present, irq;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [11:0] sample_angle, angle_out, tgt, a;
  logic [1:0] power_mode;
  logic [4:0] up [1:7];
  int num_errors, cmp_count, seed, k;
  afp_top #(.IDLE_CYCLES(50)) dut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .sample_valid, .sample_angle, .field_fail_level, .pwm_frame_level, .out_pin, .angle_out,
    .magnet_present, .power_mode, .irq);
  afp_frontend fe (.clk_sys, .rst, .target(tgt), .sample_valid, .sample_angle, .pwm_frame_level);
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      num_errors++;
    end
  endtask : check
  task automatic summarize;
    if (num_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tick(1);
    reg_wr <= 1'b0;
    tick(1);
  endtask : wr
  task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    tick(1);
    reg_rd <= 1'b0;
    // Read data stand from this edge to the next; look once they have settled
    #1;
    check(reg_rdata, e);
    tick(1);
  endtask : rdc
  // Waits for n samples of v, then until the result has landed
  task automatic samp(input logic [11:0] v, input int n);
    int j;
    tgt <= v;
    repeat (n)
    begin
      tick(1);
      for (j = 0; j < 20 && sample_valid !== 1'b1; j++)
        tick(1);
      if (j == 20)
      begin
        num_errors++;
        summarize();
      end
    end
    tick(3);
  endtask : samp
  initial
  begin
    seed = 99171;
    num_errors = 0;
    cmp_count = 0;
    up = '{5'd6, 5'd7, 5'd9, 5'd18, 5'd21, 5'd24, 5'd10};
    rst <= 1'b1;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= 8'h00;
    reg_wdata <= 32'h0;
    field_fail_level <= 1'b0;
    tgt <= 12'h000;
    tick(6);
    rst <= 1'b0;
    tick(1);
    rdc(8'h00, 32'h0);
    rdc(8'h20, 32'h0);
    for (k = 1; k < 4; k++)
    begin
      wr(8'h00, k << 7);
      tick(1);
      check(power_mode, k);
    end
    wr(8'h00, 32'h3);
    samp(12'h800, 1);
    check(angle_out !== 12'h800, 1);
    for (k = 1; k < 8; k++)
    begin
      wr(8'h00, 32'h3 | (k << 2));
      a = (k[0] ? 12'h900 : 12'h100) + 12'($random(seed) & 32'h3ff);
      samp(a, 2);
      samp(a + up[k], 1);
      check(angle_out !== a + up[k], 1);
      a = a + 12'h200;
      samp(a, 2);
      samp(a + up[k] + 12'h1, 1);
      check(angle_out, a + up[k] + 12'h1);
    end
    for (k = 2; k < 4; k++)
    begin
      wr(8'h00, 32'h4 | (k << 5));
      a = k[0] ? 12'ha00 : 12'h300;
      samp(a, 1);
      check(angle_out, a);
      samp(a + k, 1);
      check(angle_out, a);
      rdc(8'h14, {20'h00000, a});
    end
    // Hysteresis kept at 3 so the held angle does not move without a sample
    wr(8'h00, 32'h460);
    wr(8'h0c, 32'h7);
    wr(8'h10, 32'h7);
    tick(1);
    check(irq, 0);
    field_fail_level <= 1'b1;
    tick(8);
    check(magnet_present, 0);
    check(out_pin, 0);
    check(irq, 1);
    rdc(8'h08, 32'h1);
    rdc(8'h04, 32'h0);
    wr(8'h0c, 32'h0);
    tick(1);
    check(irq, 0);
    wr(8'h10, 32'h7);
    wr(8'h0c, 32'h7);
    tick(1);
    check(irq, 0);
    field_fail_level <= 1'b0;
    tick(8);
    check(magnet_present, 1);
    rdc(8'h08, 32'h2);
    for (k = 0; k < 60 && out_pin !== 1'b1; k++)
      tick(1);
    check(out_pin, 1);
    wr(8'h00, 32'h2e0);
    tick(20);
    check(power_mode, 1);
    for (k = 0; k < 300 && power_mode !== 2'h3; k++)
      tick(1);
    check(power_mode, 3);
    if (k == 300)
      summarize();
    samp(tgt + 12'h200, 1);
    check(power_mode, 1);
    wr(8'h00, 32'h0e0);
    tick(100);
    check(power_mode, 1);
    summarize();
  end
endmodule : tb
`default_nettype wire
